// >>> ctb_pkg.sv
// Purpose: Shared constants and types for the counter array time base.
// Assumes: Clock is the system oscillator, 250 MHz, one period 4 ns.
// Notes: Special function register offsets are byte addresses.
package ctb_pkg;

  // Special function register addresses
  localparam logic [7:0] CTB_ADDR_CONTROL = 8'hD8;
  localparam logic [7:0] CTB_ADDR_MODE = 8'hD9;
  localparam logic [7:0] CTB_ADDR_MOD_MODE0 = 8'hDA;
  localparam logic [7:0] CTB_ADDR_COUNT_LO = 8'hE9;
  localparam logic [7:0] CTB_ADDR_COUNT_HI = 8'hF9;
  localparam logic [7:0] CTB_ADDR_CAP_LO0 = 8'hEA;
  localparam logic [7:0] CTB_ADDR_CAP_HI0 = 8'hFA;

  // Number of compare/capture modules
  localparam int CTB_NUM_MOD = 5;
  // Module that carries the watchdog function
  localparam int CTB_WDOG_MOD = 4;

  // Mode register field positions
  localparam int CTB_MODE_IDLE_GATE = 7;
  localparam int CTB_MODE_WDOG_EN = 6;
  localparam int CTB_MODE_SEL_HI = 2;
  localparam int CTB_MODE_SEL_LO = 1;
  localparam int CTB_MODE_OVF_IE = 0;
  // Control register field positions
  localparam int CTB_CTL_OVF_FLAG = 7;
  localparam int CTB_CTL_RUN = 6;

  // Reset values
  localparam logic [7:0] CTB_MODE_RESET = 8'h00;
  localparam logic [7:0] CTB_CTL_RESET = 8'h00;
  localparam logic [6:0] CTB_MOD_MODE_RESET = 7'h00;
  localparam logic [15:0] CTB_COUNT_RESET = 16'h0000;

  // Count source codes
  localparam logic [1:0] CTB_SEL_DIV12 = 2'h0;
  localparam logic [1:0] CTB_SEL_DIV4 = 2'h1;
  localparam logic [1:0] CTB_SEL_T0OVF = 2'h2;
  localparam logic [1:0] CTB_SEL_EXT = 2'h3;

  // Oscillator periods per count, normal and double speed
  localparam logic [3:0] CTB_DIV12_NORM = 4'hC;
  localparam logic [3:0] CTB_DIV12_FAST = 4'h6;
  localparam logic [3:0] CTB_DIV4_NORM = 4'h4;
  localparam logic [3:0] CTB_DIV4_FAST = 4'h2;

  // Per-module mode bits, msb first as in the mode register
  typedef struct packed {
    logic cmp_en;
    logic cap_rise;
    logic cap_fall;
    logic match_flag;
    logic toggle;
    logic pwm;
    logic irq_en;
  } ctb_mod_mode_t;

  // Special function register access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ctb_sfr_req_t;

endpackage

// >>> ctb_cc_unit.sv
// Purpose: One compare/capture module working against the shared count.
// Assumes: pin_i is already synchronised to the clock.
// Notes: Capture, software timer, high-speed output and 8-bit PWM.
`timescale 1ns/1ps
module ctb_cc_unit
  import ctb_pkg::*;
(
  // Clock, reset, enable
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic ce_i,
  // Shared time base
  input wire logic [15:0] count_i,
  input wire logic moved_i,
  // Control
  input wire ctb_mod_mode_t mode_i,
  input wire logic wr_lo_i,
  input wire logic wr_hi_i,
  input wire logic [7:0] wdata_i,
  input wire logic pin_i,
  // Results
  output logic [15:0] cap_o,
  output logic pin_o,
  output logic event_o,
  output logic match_o
);

  logic pin_q; // Previous pin level for edge detection
  logic rise; // Rising edge seen on the pin
  logic fall; // Falling edge seen on the pin
  logic hit; // Counter equals compare value after a move
  logic capture; // Capture condition this cycle

  assign rise = pin_i & ~pin_q;
  assign fall = ~pin_i & pin_q;
  assign capture = (mode_i.cap_rise & rise) | (mode_i.cap_fall & fall);
  assign hit = moved_i & mode_i.cmp_en & ~mode_i.pwm & (count_i == cap_o);

  // Pin history
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      pin_q <= 1'b1; // Idle level of the pulled-up pin
    else if (ce_i)
      pin_q <= pin_i;
  end

  // Compare/capture value: capture, software write, PWM reload
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      cap_o <= CTB_COUNT_RESET;
    else if (ce_i)
    begin
      if (capture)
        cap_o <= count_i;
      else if (wr_lo_i)
        cap_o[7:0] <= wdata_i;
      else if (wr_hi_i)
        cap_o[15:8] <= wdata_i;
      else if (mode_i.pwm && moved_i && count_i[7:0] == 8'hFF)
        cap_o[7:0] <= cap_o[15:8]; // Duty reload when the low byte reaches FF
    end
  end

  // Pin output: toggle on match or pulse width compare
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      pin_o <= 1'b0;
    else if (ce_i)
    begin
      if (mode_i.pwm && mode_i.cmp_en)
        pin_o <= (count_i[7:0] >= cap_o[7:0]);
      else if (hit && mode_i.toggle)
        pin_o <= ~pin_o; // High-speed output
    end
  end

  // Event pulse for the module flag; match pulse for the watchdog
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      event_o <= 1'b0;
      match_o <= 1'b0;
    end
    else if (ce_i)
    begin
      event_o <= capture | (hit & mode_i.match_flag);
      match_o <= hit;
    end
  end

endmodule

// >>> ctb_timebase.sv
// Purpose: Common 16-bit time base of a five-module counter array.
// Assumes: Core reaches registers through its SFR strobes on this clock.
// Notes: Pins of port 1 bits 2..7 enter through two-stage synchronisers.
`timescale 1ns/1ps
// What this block does
// - code 00 counts every 12, or 6
// - code 01 counts every 4, or 2
// - code 10 counts timer 0 overflows
// - code 11 counts external pin falling edges, slow
// - idle gating bit stops counting in idle
// - watchdog bit enables module 4 watchdog
// - overflow interrupt only when enable set
// - all requests merged into one line
// - capture, timer, high-speed output modes raise events
// - one counter is time base for modules
// - port 1 bits 2..7 carry array pins
// - modules capture, time, output, modulate widths
// - overflow flag set by wrap, software clears
// - counter counts only while run bit set
module ctb_timebase
  import ctb_pkg::*;
(
  // Clock, reset, enable
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  // Core status
  input wire logic IDLE_I,
  input wire logic DOUBLE_SPEED_I,
  input wire logic T0_OVF_I,
  // Special function register access
  input wire ctb_sfr_req_t SFR_I,
  output logic [7:0] SFR_RDATA_O,
  // Port 1 pins
  input wire logic [7:2] P1_I,
  output logic [7:3] P1_O,
  output logic [7:3] P1_OE_O,
  // Results to the core
  output logic IRQ_O,
  output logic WDOG_RESET_O
);

  logic [7:0] array_counter_mode; // Mode register
  logic [7:0] array_counter_control; // Control register, module flags low, overflow flag in bit 7
  ctb_mod_mode_t mod_mode [CTB_NUM_MOD]; // Per-module modes
  logic [15:0] count; // Shared time base
  logic [3:0] presc; // Oscillator period counter
  logic [3:0] div; // Periods per count for the chosen division
  logic [7:2] pin_s1; // First synchroniser stage
  logic [7:2] pin_s2; // Second synchroniser stage
  logic ext_q; // Previous external count input level
  logic src_pulse; // Selected count source fired
  logic run; // Counter allowed to advance
  logic tick; // Counter advances this cycle
  logic moved; // Counter advanced last cycle
  logic wrap; // Counter wraps this cycle
  logic [15:0] next_count; // Count plus one, loaded only on a tick
  logic [CTB_NUM_MOD-1:0] mod_event; // Module event pulses
  logic [CTB_NUM_MOD-1:0] mod_match; // Module match pulses
  logic [CTB_NUM_MOD-1:0] mod_pin; // Module pin outputs
  logic [CTB_NUM_MOD-1:0] mod_ie; // Module interrupt enables
  logic [15:0] mod_cap [CTB_NUM_MOD]; // Module values
  logic [1:0] sel; // Count source code

  assign sel = {array_counter_mode[CTB_MODE_SEL_HI],
                array_counter_mode[CTB_MODE_SEL_LO]};

  // Division chosen by source code and speed mode
  always_comb
  begin
    if (sel == CTB_SEL_DIV12)
      div = DOUBLE_SPEED_I ? CTB_DIV12_FAST : CTB_DIV12_NORM;
    else
      div = DOUBLE_SPEED_I ? CTB_DIV4_FAST : CTB_DIV4_NORM;
  end

  // Count source pulse
  always_comb
  begin
    case (sel)
      CTB_SEL_T0OVF: src_pulse = T0_OVF_I;
      CTB_SEL_EXT: src_pulse = ext_q & ~pin_s2[2];
      default: src_pulse = (presc == div - 4'h1);
    endcase
  end

  // Run when enabled and not gated by idle
  assign run = array_counter_control[CTB_CTL_RUN]
    & ~(array_counter_mode[CTB_MODE_IDLE_GATE] & IDLE_I);
  assign tick = run & src_pulse;
  assign next_count = count + 16'h0001;
  assign wrap = tick & (count == 16'hFFFF);

  // Pin synchronisers
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      pin_s1 <= '1; // Pulled-up idle level, so no false edge
      pin_s2 <= '1;
      ext_q <= 1'b1;
    end
    else if (CE_I)
    begin
      pin_s1 <= P1_I;
      pin_s2 <= pin_s1;
      ext_q <= pin_s2[2]; // External count input history
    end
  end

  // Oscillator period counter, restarts at once when a shorter division leaves it out of range
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      presc <= 4'h0;
    else if (CE_I)
    begin
      if (presc >= div - 4'h1)
        presc <= 4'h0;
      else
        presc <= presc + 4'h1;
    end
  end

  // Shared counter, software may load either byte
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      count <= CTB_COUNT_RESET;
      moved <= 1'b0;
    end
    else if (CE_I)
    begin
      moved <= tick;
      if (SFR_I.wr && SFR_I.addr == CTB_ADDR_COUNT_LO)
        count[7:0] <= SFR_I.wdata;
      else if (SFR_I.wr && SFR_I.addr == CTB_ADDR_COUNT_HI)
        count[15:8] <= SFR_I.wdata;
      else if (tick)
        count <= next_count;
    end
  end

  // Mode registers
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      array_counter_mode <= CTB_MODE_RESET;
      for (int i = 0; i < CTB_NUM_MOD; i++)
        mod_mode[i] <= CTB_MOD_MODE_RESET;
    end
    else if (CE_I && SFR_I.wr)
    begin
      if (SFR_I.addr == CTB_ADDR_MODE)
        array_counter_mode <= SFR_I.wdata;
      for (int i = 0; i < CTB_NUM_MOD; i++)
        if (SFR_I.addr == CTB_ADDR_MOD_MODE0 + 8'(i))
          mod_mode[i] <= SFR_I.wdata[6:0];
    end
  end

  // Control register: hardware set wins over a software clear
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      array_counter_control <= CTB_CTL_RESET;
    else if (CE_I)
    begin
      if (SFR_I.wr && SFR_I.addr == CTB_ADDR_CONTROL)
        array_counter_control <= {SFR_I.wdata[7:6], 1'b0, SFR_I.wdata[4:0]}
          | {wrap, 2'b00, mod_event};
      else
        array_counter_control <= array_counter_control
          | {wrap, 2'b00, mod_event};
    end
  end

  // Compare/capture modules
  generate
    for (genvar g = 0; g < CTB_NUM_MOD; g++)
    begin : g_mod
      assign mod_ie[g] = mod_mode[g].irq_en;
      ctb_cc_unit u_unit (
        .CLK_I(CLK_I),
        .NRST_I(NRST_I),
        .ce_i(CE_I),
        .count_i(count),
        .moved_i(moved),
        .mode_i(mod_mode[g]),
        .wr_lo_i(SFR_I.wr && SFR_I.addr == CTB_ADDR_CAP_LO0 + 8'(g)),
        .wr_hi_i(SFR_I.wr && SFR_I.addr == CTB_ADDR_CAP_HI0 + 8'(g)),
        .wdata_i(SFR_I.wdata),
        .pin_i(pin_s2[3 + g]),
        .cap_o(mod_cap[g]),
        .pin_o(mod_pin[g]),
        .event_o(mod_event[g]),
        .match_o(mod_match[g])
      );
    end
  endgenerate

  // Module pins drive port 1 only in an output mode
  assign P1_O = mod_pin;

  // Output enables, interrupt and watchdog from flops
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      P1_OE_O <= '0;
      IRQ_O <= 1'b0;
      WDOG_RESET_O <= 1'b0;
    end
    else if (CE_I)
    begin
      for (int i = 0; i < CTB_NUM_MOD; i++)
        P1_OE_O[3 + i] <= mod_mode[i].cmp_en
          & (mod_mode[i].toggle | mod_mode[i].pwm);
      IRQ_O <= (array_counter_control[CTB_CTL_OVF_FLAG]
        & array_counter_mode[CTB_MODE_OVF_IE])
        | |(array_counter_control[4:0] & mod_ie);
      WDOG_RESET_O <= mod_match[CTB_WDOG_MOD]
        & array_counter_mode[CTB_MODE_WDOG_EN];
    end
  end

  // Read data: address decode into a registered byte
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      SFR_RDATA_O <= 8'h00;
    else if (CE_I && SFR_I.rd)
    begin
      SFR_RDATA_O <= 8'h00;
      if (SFR_I.addr == CTB_ADDR_CONTROL)
        SFR_RDATA_O <= array_counter_control;
      else if (SFR_I.addr == CTB_ADDR_MODE)
        SFR_RDATA_O <= array_counter_mode;
      else if (SFR_I.addr == CTB_ADDR_COUNT_LO)
        SFR_RDATA_O <= count[7:0];
      else if (SFR_I.addr == CTB_ADDR_COUNT_HI)
        SFR_RDATA_O <= count[15:8];
      for (int i = 0; i < CTB_NUM_MOD; i++)
      begin
        if (SFR_I.addr == CTB_ADDR_MOD_MODE0 + 8'(i))
          SFR_RDATA_O <= {1'b0, mod_mode[i]};
        else if (SFR_I.addr == CTB_ADDR_CAP_LO0 + 8'(i))
          SFR_RDATA_O <= mod_cap[i][7:0];
        else if (SFR_I.addr == CTB_ADDR_CAP_HI0 + 8'(i))
          SFR_RDATA_O <= mod_cap[i][15:8];
      end
    end
  end

endmodule

// >>> ctb_timebase_monitor.sv
// Purpose: Port-level checker for the counter array time base.
// Assumes: Sees only the top module's ports, one clock domain.
// Notes: Shadows of software writes stand in for internal state.
`timescale 1ns/1ps
module ctb_timebase_monitor
  import ctb_pkg::*;
(
  // Clock, reset, enable
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  // Register access
  input wire ctb_sfr_req_t SFR_I,
  input wire logic [7:0] SFR_RDATA_O,
  // Results
  input wire logic [7:3] P1_OE_O,
  input wire logic IRQ_O,
  input wire logic WDOG_RESET_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  logic [7:0] mode; // Last mode register write
  logic run; // Last run bit write
  logic [4:0] drive; // Modules allowed to drive their pin
  logic [4:0] irq_en; // Module interrupt enables
  logic [1:0] wd_off; // Cycles since watchdog off, saturating
  logic wr_ok; // Write taken this edge
  logic [2:0] mod_idx; // Module addressed by a mode write
  assign wr_ok = CE_I && SFR_I.wr;
  assign mod_idx = SFR_I.addr[2:0] - 3'h2;
  // Follow what software writes
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      mode <= CTB_MODE_RESET;
      run <= 1'b0;
      drive <= 5'h00;
      irq_en <= 5'h00;
    end
    else if (wr_ok && SFR_I.addr == CTB_ADDR_MODE)
      mode <= SFR_I.wdata;
    else if (wr_ok && SFR_I.addr == CTB_ADDR_CONTROL)
      run <= SFR_I.wdata[CTB_CTL_RUN];
    else if (wr_ok && SFR_I.addr[7:3] == 5'h1B && mod_idx < 3'h5)
    begin
      drive[mod_idx] <= SFR_I.wdata[6] & (|SFR_I.wdata[2:1]);
      irq_en[mod_idx] <= SFR_I.wdata[0];
    end
  end
  // Count how long the watchdog has been off
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      wd_off <= 2'h0;
    else if (mode[CTB_MODE_WDOG_EN])
      wd_off <= 2'h0;
    else if (wd_off != 2'h3)
      wd_off <= wd_off + 2'h1;
  end
  chk_mode_readback:
    assert property (CE_I && SFR_I.rd && SFR_I.addr == CTB_ADDR_MODE
      |=> (SFR_RDATA_O & 8'hC7) == ($past(mode) & 8'hC7))
    else $error("mode readback differs from last write");
  chk_run_readback:
    assert property (CE_I && SFR_I.rd && SFR_I.addr == CTB_ADDR_CONTROL
      |=> SFR_RDATA_O[CTB_CTL_RUN] == $past(run) && !SFR_RDATA_O[5])
    else $error("run bit readback wrong");
  chk_wdog_off:
    assert property (wd_off == 2'h3 |-> !WDOG_RESET_O)
    else $error("watchdog pulse while disabled");
  chk_wdog_pulse:
    assert property (WDOG_RESET_O |=> !WDOG_RESET_O)
    else $error("watchdog pulse longer than one cycle");
  chk_irq_quiet:
    assert property (!mode[0] && !$past(mode[0]) && irq_en == 5'h00
      && $past(irq_en) == 5'h00 |-> !IRQ_O)
    else $error("interrupt with every enable off");
  chk_irq_sw_flag:
    assert property (wr_ok && SFR_I.addr == CTB_ADDR_CONTROL
      && SFR_I.wdata[7] && mode[0] |-> ##[1:2] IRQ_O)
    else $error("set overflow flag raised no interrupt");
  chk_flag_clear:
    assert property (wr_ok && SFR_I.addr == CTB_ADDR_CONTROL
      && SFR_I.wdata == 8'h00 && irq_en == 5'h00 |-> ##[1:2] !IRQ_O)
    else $error("cleared flags still interrupt");
  chk_pin_release:
    assert property ((P1_OE_O & ~(drive | $past(drive)
      | $past(drive, 2))) == 5'h00)
    else $error("pin driven by a module not in output mode");
endmodule

// >>> ctb_core_model.sv
// Purpose: Behavioural core issuing register accesses and timer 0 events.
// Assumes: Requests change on the falling edge, one at a time.
// Notes: Released address and data show the inverse of the last value.
`timescale 1ns/1ps
module ctb_core_model
  import ctb_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Register access
  output ctb_sfr_req_t sfr_o,
  input wire logic [7:0] rdata_i,
  // Timer 0 overflow
  output logic t0_ovf_o
);
  // Quiet bus at time zero
  initial
  begin
    sfr_o = '0;
    t0_ovf_o = 1'b0;
  end
  // Drop strobes and scramble what is no longer valid
  task automatic release_bus;
    sfr_o.wr = 1'b0;
    sfr_o.rd = 1'b0;
    sfr_o.addr = ~sfr_o.addr;
    sfr_o.wdata = ~sfr_o.wdata;
  endtask
  // One write; software runs and stops the counter this way
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    sfr_o.addr = a;
    sfr_o.wdata = d;
    sfr_o.wr = 1'b1;
    @(negedge clk_i);
    release_bus();
  endtask
  // One read; data is taken the cycle after the strobe
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    sfr_o.addr = a;
    sfr_o.rd = 1'b1;
    @(negedge clk_i);
    release_bus();
    d = rdata_i;
  endtask
  // Single-cycle overflow event
  task automatic t0_pulse;
    @(negedge clk_i);
    t0_ovf_o = 1'b1;
    @(negedge clk_i);
    t0_ovf_o = 1'b0;
  endtask
endmodule

// >>> ctb_timebase_tb.sv
// Purpose: Self-checking bench for the counter array time base.
// Assumes: Inputs change on the falling edge of a 250 MHz clock.
// Notes: Count rates are measured over exact windows of run time.
`timescale 1ns/1ps
module ctb_timebase_tb;
  import ctb_pkg::*;
  logic clk = 1'b0; // System clock
  logic nrst = 1'b0; // Reset, active low
  logic idle = 1'b0; // Core idle
  logic dsp = 1'b0; // Double speed
  logic [7:2] p1 = 6'h3F; // Port pins, idle high
  logic t0, irq, wdog;
  logic [7:0] rdata, v;
  logic [7:3] p1_out, p1_oe;
  ctb_sfr_req_t sfr;
  int fails = 0;
  int total_checks = 0;
  int wd_seen = 0; // Watchdog pulses seen
  int wd_base = 0; // Pulses seen before a run
  logic ce = 1'b1; // Clock enable
  int divs[4] = '{12, 6, 4, 2};
  always #2 clk = ~clk;
  always @(posedge clk) wd_seen <= wd_seen + int'(wdog === 1'b1);
  ctb_core_model core (.clk_i(clk), .sfr_o(sfr), .rdata_i(rdata),
    .t0_ovf_o(t0));
  ctb_timebase DUT (.CLK_I(clk), .NRST_I(nrst), .CE_I(ce),
    .IDLE_I(idle), .DOUBLE_SPEED_I(dsp), .T0_OVF_I(t0), .SFR_I(sfr),
    .SFR_RDATA_O(rdata), .P1_I(p1), .P1_O(p1_out), .P1_OE_O(p1_oe),
    .IRQ_O(irq), .WDOG_RESET_O(wdog));
  // Compare and count
  task automatic check(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic tally_and_finish;
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Read both count bytes
  task automatic count_is(input logic [15:0] exp);
    logic [7:0] lo, hi;
    core.sfr_rd(CTB_ADDR_COUNT_LO, lo);
    core.sfr_rd(CTB_ADDR_COUNT_HI, hi);
    check("count", {hi, lo}, exp);
  endtask
  // Zero the count, select the source
  task automatic setup(input logic [7:0] m);
    core.sfr_wr(CTB_ADDR_MODE, m);
    core.sfr_wr(CTB_ADDR_COUNT_LO, 8'h00);
    core.sfr_wr(CTB_ADDR_COUNT_HI, 8'h00);
  endtask
  // Run for exactly n clock edges
  task automatic run_for(input int n);
    core.sfr_wr(CTB_ADDR_CONTROL, 8'h40);
    repeat (n - 2) @(negedge clk);
    core.sfr_wr(CTB_ADDR_CONTROL, 8'h00);
  endtask
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
  // Main sequence
  initial
  begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    core.sfr_rd(CTB_ADDR_MODE, v);
    check("mode reset", v, CTB_MODE_RESET);
    core.sfr_rd(CTB_ADDR_CONTROL, v);
    check("control reset", v, CTB_CTL_RESET);
    core.sfr_rd(8'h10, v);
    check("unmapped", v, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      dsp = i[0];
      repeat (16) @(negedge clk);
      setup(i[1] ? 8'h02 : 8'h00);
      run_for(5 * divs[i]);
      count_is(16'h0005);
    end
    setup(8'h04);
    core.sfr_wr(CTB_ADDR_CONTROL, 8'h40);
    repeat (3) core.t0_pulse();
    core.sfr_wr(CTB_ADDR_CONTROL, 8'h00);
    count_is(16'h0003);
    setup(8'h06);
    core.sfr_wr(CTB_ADDR_CONTROL, 8'h40);
    repeat (4)
    begin
      p1[2] = 1'b0;
      repeat (4) @(negedge clk);
      p1[2] = 1'b1;
      repeat (4) @(negedge clk);
    end
    repeat (6) @(negedge clk);
    core.sfr_wr(CTB_ADDR_CONTROL, 8'h00);
    count_is(16'h0004);
    dsp = 1'b0;
    idle = 1'b1;
    for (int g = 0; g < 2; g++)
    begin
      setup(g ? 8'h82 : 8'h02);
      run_for(40);
      count_is(g ? 16'h0000 : 16'h000A);
    end
    idle = 1'b0;
    setup(8'h02);
    core.sfr_wr(CTB_ADDR_COUNT_LO, 8'hFE);
    core.sfr_wr(CTB_ADDR_COUNT_HI, 8'hFF);
    core.sfr_wr(CTB_ADDR_CONTROL, 8'h40);
    repeat (12) @(negedge clk);
    core.sfr_rd(CTB_ADDR_CONTROL, v);
    check("overflow flag", v, 8'hC0);
    check("irq masked", irq, 1'b0);
    core.sfr_wr(CTB_ADDR_MODE, 8'h03);
    @(negedge clk);
    check("irq enabled", irq, 1'b1);
    core.sfr_wr(CTB_ADDR_CONTROL, 8'h80);
    core.sfr_wr(CTB_ADDR_CONTROL, 8'h00);
    repeat (2) @(negedge clk);
    check("irq cleared", irq, 1'b0);
    for (int w = 0; w < 2; w++)
    begin
      core.sfr_wr(8'hEE, 8'h05);
      core.sfr_wr(8'hFE, 8'h00);
      core.sfr_wr(8'hDE, 8'h40);
      setup(w ? 8'h42 : 8'h02);
      wd_base = wd_seen;
      run_for(40);
      check("watchdog", 16'(wd_seen - wd_base), 16'(w));
    end
    core.sfr_wr(CTB_ADDR_MOD_MODE0, 8'h44);
    repeat (3) @(negedge clk);
    check("pin drive", p1_oe, 5'h01);
    core.sfr_wr(CTB_ADDR_CAP_LO0, 8'h80);
    core.sfr_wr(CTB_ADDR_MOD_MODE0, 8'h42);
    repeat (3) @(negedge clk);
    check("pwm low", p1_out, 5'h00);
    check("pwm drive", p1_oe, 5'h01);
    core.sfr_wr(CTB_ADDR_COUNT_LO, 8'h90);
    repeat (3) @(negedge clk);
    check("pwm high", p1_out, 5'h01);
    core.sfr_wr(CTB_ADDR_MOD_MODE0, 8'h00);
    repeat (3) @(negedge clk);
    check("pin release", p1_oe, 5'h00);
    core.sfr_wr(CTB_ADDR_CAP_LO0, 8'h93);
    core.sfr_wr(CTB_ADDR_MOD_MODE0, 8'h49);
    core.sfr_wr(CTB_ADDR_CONTROL, 8'h40);
    repeat (20) @(negedge clk);
    check("module irq", irq, 1'b1);
    core.sfr_rd(CTB_ADDR_CONTROL, v);
    check("module flag", v, 8'h41);
    core.sfr_wr(CTB_ADDR_CONTROL, 8'h00);
    repeat (2) @(negedge clk);
    check("module irq clear", irq, 1'b0);
    core.sfr_wr(CTB_ADDR_COUNT_LO, 8'h3C);
    core.sfr_wr(CTB_ADDR_MOD_MODE0 + 8'h01, 8'h10);
    p1[4] = 1'b0;
    repeat (6) @(negedge clk);
    core.sfr_rd(CTB_ADDR_CAP_LO0 + 8'h01, v);
    check("capture", v, 8'h3C);
    core.sfr_rd(CTB_ADDR_CONTROL, v);
    check("capture flag", v, 8'h02);
    p1[4] = 1'b1;
    setup(8'h02);
    core.sfr_wr(CTB_ADDR_CONTROL, 8'h40);
    ce = 1'b0;
    repeat (40) @(negedge clk);
    ce = 1'b1;
    repeat (18) @(negedge clk);
    core.sfr_wr(CTB_ADDR_CONTROL, 8'h00);
    count_is(16'h0005);
    tally_and_finish();
  end
endmodule
bind ctb_timebase ctb_timebase_monitor u_mon (.CLK_I, .NRST_I, .CE_I,
  .SFR_I, .SFR_RDATA_O, .P1_OE_O, .IRQ_O, .WDOG_RESET_O);
